// ===== verif/dsc_host.sv
// Host side of the three-wire write port
module dsc_host (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic sdata,
	output logic lock
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b0;
		sclk = 1'b0;
		sdata = 1'b0;
		lock = 1'b0;
	end
	task power_up;
		@(posedge clk) lock <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// lock-controlled frame, 4 sys clocks a level
	task send(input logic [15:0] w, input int n, input bit seq);
		lock <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			// Overlong frames wrap the index, so extra leading bits stay defined
			sdata <= w[(n - 1 - i) % dsc_pkg::FRAME_BITS];
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		sclk <= 1'b0;
		lock <= !seq;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		// Released data line shows junk, not the last bit
		sdata <= ~sdata;
		repeat (4) @(posedge clk);
		lock <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// Clock activity with select high, to be ignored
	task noise;
		repeat (6) begin
			repeat (4) @(posedge clk);
			sclk <= ~sclk;
			sdata <= ~sdata;
		end
	endtask
endmodule // dsc_host

// ===== verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic standby_pin = 1'b0;
	logic rfsel = 1'b1;
	logic cs_n, sclk, sdata, lock, pen, stm, rfa, fok;
	logic [5:0] att;
	logic [7:0] db;
	logic [31:0] lf = 32'hFA1E5592;
	int err_count = 0;
	int n_checks = 0;
	// Free-running 50 MHz clock
	always #10 clk = ~clk;
	dsc_host h (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdata(sdata), .lock(lock));
	dsc_serial_ctrl dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CHIP_SELECT_BAR_I(cs_n),
		.SERIAL_CLOCK_I(sclk), .SERIAL_DATA_I(sdata), .ENABLE_WRITE_LOCK_I(lock),
		.STANDBY_PIN_I(standby_pin), .RF_INPUT_SELECT_I(rfsel), .ATTEN_CODE_O(att), .DATA_BYTE_O(db),
		.PATH_ENABLE_N_O(pen), .STANDBY_MODE_O(stm), .RF_ROUTE_ALTERNATE_O(rfa), .FRAME_OK_O(fok));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Codes past the top step clamp
	function logic [5:0] exp_att(input logic [7:0] d);
		return (d[6:1] > dsc_pkg::ATT_MAX_CODE) ? dsc_pkg::ATT_MAX_CODE : d[6:1];
	endfunction
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One write, then settings compared after commit latency
	task frame(input logic [15:0] w, input int n, input bit seq, input logic [7:0] ed, input logic ep, input logic eo);
		h.send(w, n, seq);
		chk(db, ed);
		chk(8'(att), 8'(exp_att(ed)));
		chk(8'(pen), 8'(ep));
		chk(8'(fok), 8'(eo));
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		#500us;
		err_count++;
		wrap_up;
	end
	// Main sequence
	initial begin
		logic [7:0] corners [7];
		corners = '{8'h00, 8'h80, 8'h01, 8'h66, 8'hE6, 8'h67, 8'h7E};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(att), 8'h33);
		chk(db, 8'h66);
		chk(8'(pen), 8'h00);
		chk(8'(stm), 8'h00);
		h.power_up;
		$display("reset defaults done");
		for (int i = 0; i < 12; i++) begin
			lf = lfsr(lf);
			standby_pin <= lf[20];
			rfsel <= lf[21];
			frame(lf[15:0], 16, 0, lf[7:0], 1'b0, 1'b1);
			chk(8'(stm), 8'(lf[20]));
			chk(8'(rfa), 8'(lf[21]));
		end
		foreach (corners[i])
			frame({8'h01, corners[i]}, 16, 0, corners[i], 1'b0, 1'b1);
		$display("random and corner frames done");
		frame(16'h0155, 16, 1, 8'h55, 1'b1, 1'b1);
		frame(16'h0044, 16, 0, 8'h44, 1'b1, 1'b1);
		frame(16'h0000, 16, 1, 8'h00, 1'b0, 1'b1);
		frame(16'h00A4, 8, 1, 8'hA4, 1'b0, 1'b0);
		$display("lock and short frames done");
		h.noise;
		repeat (8) @(posedge clk);
		chk(db, 8'hA4);
		chk(8'(att), 8'h12);
		frame(16'h0166, 16, 0, 8'h66, 1'b0, 1'b1);
		$display("idle clock test done");
		frame(16'h0133, 17, 1, 8'h33, 1'b1, 1'b0);
		$display("overlong frame test done");
		wrap_up;
	end
endmodule // testbench

// ===== verilog/dsc_pkg.sv
package dsc_pkg;

	// Frame layout: address byte first, then data byte, MSB first
	localparam int FRAME_BITS = 16;
	localparam int SHIFT_W = 16;
	localparam int BYTE_BITS = 8;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] CNT_FRAME = 5'h10;
	localparam logic [4:0] CNT_SAT = 5'h11;

	// Field positions inside the shift register at commit time
	localparam int DATA_LSB = 0;
	localparam int ADDR_EN_POS = 8;
	localparam int ATT_LSB = 1;
	localparam int ATT_MSB = 6;
	localparam int ATT_W = 6;

	// Attenuation coding: code times 0.5 dB, largest legal code is 25.5 dB
	localparam int ATT_STEP_TENTHS_DB = 5;
	localparam int ATT_RANGE_TENTHS_DB = 255;
	localparam logic [5:0] ATT_MAX_CODE = 6'(ATT_RANGE_TENTHS_DB / ATT_STEP_TENTHS_DB);

	// Power-on defaults
	localparam logic [7:0] DATA_RESET = 8'h66;
	localparam logic PATH_EN_N_RESET = 1'b0;

	// Write-cycle state
	typedef enum logic [0:0] {
		DSC_ST_IDLE = 1'b0,
		DSC_ST_SHIFT = 1'b1
	} dsc_state_t;

endpackage : dsc_pkg

// ===== verilog/dsc_serial_ctrl.sv
// Notes on behaviour
// - Defaults: maximum attenuation, not in standby.
// - MSB first, address byte before data.
// - Serial clock ignored while select high.
// - Shift data on rising serial clock.
// - Wrong clock count gives unguaranteed content.
// - Select rising edge commits shifted bits.
// - Lock high blocks path enable update.
// - Lock low lets path enable change.
// - Data always accepted; enable bit needs lock low.
// - Six-bit field, half dB per code step.
// - Field bit one means step switched in.
// - Data bits seven and zero ignored.
// - 0x66, 0xE6, 0x67 give maximum attenuation.
// - Input select high routes alternate input.
// - Select falling edge starts a write cycle.
// - Standby pin high puts device off.
module dsc_serial_ctrl (
	// System clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	// Serial control pins
	input wire logic CHIP_SELECT_BAR_I,
	input wire logic SERIAL_CLOCK_I,
	input wire logic SERIAL_DATA_I,
	input wire logic ENABLE_WRITE_LOCK_I,
	// Mode pins
	input wire logic STANDBY_PIN_I,
	input wire logic RF_INPUT_SELECT_I,
	// Active control settings and frame status flag
	output logic [5:0] ATTEN_CODE_O,
	output logic [7:0] DATA_BYTE_O,
	output logic PATH_ENABLE_N_O,
	output logic STANDBY_MODE_O,
	output logic RF_ROUTE_ALTERNATE_O,
	output logic FRAME_OK_O
);

	logic rst_s1_q, rst_n_q;
	logic cs_s1_q, cs_s2_q, cs_prev_q;
	logic clk_s1_q, clk_s2_q, clk_prev_q;
	logic dat_s1_q, dat_s2_q;
	logic lock_s1_q, lock_s2_q;
	logic standby_pin_s1_q, standby_pin_s2_q;
	logic sel_s1_q, sel_s2_q;
	logic cs_rise, cs_fall, sclk_rise;
	dsc_pkg::dsc_state_t state_q, state_d;
	logic [15:0] shift_q, shift_d;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] data_q, data_d;
	logic [5:0] att_q, att_d;
	logic path_q, path_d;
	logic ok_q, ok_d;
	logic standby_pin_q, sel_q;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Pin synchronisers; data shares the clock's latency so the two stay aligned
	always_ff @(posedge SYS_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_prev_q <= 1'b1;
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_prev_q <= 1'b0;
			dat_s1_q <= 1'b0;
			dat_s2_q <= 1'b0;
			lock_s1_q <= 1'b1;
			lock_s2_q <= 1'b1;
			standby_pin_s1_q <= 1'b0;
			standby_pin_s2_q <= 1'b0;
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= CHIP_SELECT_BAR_I;
			cs_s2_q <= cs_s1_q;
			cs_prev_q <= cs_s2_q;
			clk_s1_q <= SERIAL_CLOCK_I;
			clk_s2_q <= clk_s1_q;
			clk_prev_q <= clk_s2_q;
			dat_s1_q <= SERIAL_DATA_I;
			dat_s2_q <= dat_s1_q;
			lock_s1_q <= ENABLE_WRITE_LOCK_I;
			lock_s2_q <= lock_s1_q;
			standby_pin_s1_q <= STANDBY_PIN_I;
			standby_pin_s2_q <= standby_pin_s1_q;
			sel_s1_q <= RF_INPUT_SELECT_I;
			sel_s2_q <= sel_s1_q;
		end
	end

	// Edge detection on the second stage only
	assign cs_rise = cs_s2_q && !cs_prev_q;
	assign cs_fall = !cs_s2_q && cs_prev_q;
	assign sclk_rise = clk_s2_q && !clk_prev_q && !cs_s2_q;

	// Shift path and commit logic
	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		data_d = data_q;
		att_d = att_q;
		path_d = path_q;
		ok_d = ok_q;
		// falling select opens a new write cycle
		if (cs_fall) begin
			state_d = dsc_pkg::DSC_ST_SHIFT;
			cnt_d = dsc_pkg::CNT_ZERO;
		end
		// first bit ends up in the top position
		if (sclk_rise) begin
			shift_d = {shift_q[dsc_pkg::SHIFT_W-2:0], dat_s2_q};
			if (cs_fall) begin
				cnt_d = dsc_pkg::CNT_ONE;
			end else if (cnt_q != dsc_pkg::CNT_SAT) begin
				cnt_d = cnt_q + dsc_pkg::CNT_ONE;
			end
		end
		// rising select commits the shifted bits
		if (cs_rise) begin
			state_d = dsc_pkg::DSC_ST_IDLE;
			// only exact sixteen counts good
			// Saturated count marks overlong frames, so they never read as good
			ok_d = (cnt_q == dsc_pkg::CNT_FRAME);
			case (state_q)
				dsc_pkg::DSC_ST_SHIFT: begin
					// data byte taken whatever the lock says
					// short frames still load the last eight bits
					if (cnt_q != dsc_pkg::CNT_ZERO) begin
						data_d = shift_q[dsc_pkg::DATA_LSB +: dsc_pkg::BYTE_BITS];
						// end bits of the data byte dropped
						att_d = shift_q[dsc_pkg::ATT_MSB:dsc_pkg::ATT_LSB];
						if (att_d > dsc_pkg::ATT_MAX_CODE) begin
							att_d = dsc_pkg::ATT_MAX_CODE;
						end
					end
					// lock low lets enable bit load
					if (cnt_q >= dsc_pkg::CNT_FRAME && !lock_s2_q) begin
						path_d = shift_q[dsc_pkg::ADDR_EN_POS];
					end
				end
				dsc_pkg::DSC_ST_IDLE: begin
					data_d = data_q;
				end
				default: begin
					state_d = dsc_pkg::DSC_ST_IDLE;
				end
			endcase
		end
	end

	// reset defaults give maximum attenuation, enabled path
	// default byte is the 25.5 dB code
	always_ff @(posedge SYS_CLK_I or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= dsc_pkg::DSC_ST_IDLE;
			shift_q <= '0;
			cnt_q <= dsc_pkg::CNT_ZERO;
			data_q <= dsc_pkg::DATA_RESET;
			att_q <= dsc_pkg::ATT_MAX_CODE;
			path_q <= dsc_pkg::PATH_EN_N_RESET;
			ok_q <= 1'b0;
			standby_pin_q <= 1'b0;
			sel_q <= 1'b1;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			data_q <= data_d;
			att_q <= att_d;
			path_q <= path_d;
			ok_q <= ok_d;
			standby_pin_q <= standby_pin_s2_q;
			sel_q <= sel_s2_q;
		end
	end

	// Outputs straight from registers
	assign ATTEN_CODE_O = att_q;
	assign DATA_BYTE_O = data_q;
	assign PATH_ENABLE_N_O = path_q;
	assign STANDBY_MODE_O = standby_pin_q;
	// high or open selects alternate input
	assign RF_ROUTE_ALTERNATE_O = sel_q;
	// Only an exact sixteen-clock frame is reported good
	assign FRAME_OK_O = ok_q;

	// Checks
	sequence s_cs_rise;
		cs_s2_q && !cs_prev_q;
	endsequence

	sequence s_full_frame;
		cs_s2_q && !cs_prev_q && state_q == dsc_pkg::DSC_ST_SHIFT && cnt_q >= dsc_pkg::CNT_FRAME;
	endsequence

	a_clamp_max: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		att_q <= dsc_pkg::ATT_MAX_CODE) else $error("attenuation code above maximum");

	a_sclk_ignore: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		cs_s2_q && cs_prev_q |=> $stable(shift_q)) else $error("shift moved while deselected");

	a_shift_msb: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		sclk_rise |=> shift_q == {$past(shift_q[dsc_pkg::SHIFT_W-2:0]), $past(dat_s2_q)}) else $error("bad shift");

	a_lock_hold: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_cs_rise ##0 lock_s2_q |=> $stable(path_q)) else $error("enable changed under lock");

	a_path_load: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_full_frame ##0 !lock_s2_q |=> path_q == $past(shift_q[dsc_pkg::ADDR_EN_POS]))
		else $error("enable bit not loaded");

	a_short_keep: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_cs_rise ##0 cnt_q < dsc_pkg::CNT_FRAME |=> $stable(path_q)) else $error("short frame hit enable");

	a_data_commit: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_cs_rise ##0 (state_q == dsc_pkg::DSC_ST_SHIFT && cnt_q != dsc_pkg::CNT_ZERO)
		|=> data_q == $past(shift_q[dsc_pkg::DATA_LSB +: dsc_pkg::BYTE_BITS])) else $error("data byte not committed");

	a_att_field: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_cs_rise ##0 (state_q == dsc_pkg::DSC_ST_SHIFT && cnt_q != dsc_pkg::CNT_ZERO)
		##0 shift_q[dsc_pkg::ATT_MSB:dsc_pkg::ATT_LSB] <= dsc_pkg::ATT_MAX_CODE
		|=> att_q == $past(shift_q[dsc_pkg::ATT_MSB:dsc_pkg::ATT_LSB]))
		else $error("attenuation field mismatch");

	a_frame_ok: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		s_cs_rise |=> ok_q == ($past(cnt_q) == dsc_pkg::CNT_FRAME)) else $error("frame flag wrong");

	a_standby_pin_follow: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n_q)
		$rose(standby_pin_s2_q) |=> STANDBY_MODE_O) else $error("standby not followed");

endmodule // dsc_serial_ctrl
